// ==== common/rba_pkg.sv ====
// rba_pkg: widths, mode codes and operation codes of the register bit address unit.
// assumes one cpu clock; the decoder drives one request at a time.
package rba_pkg;
   localparam int RBA_PTR_W = 16;
   localparam int RBA_DATA_W = 40;
   localparam int RBA_BIT_W = 6;
   localparam logic [RBA_PTR_W-1:0] RBA_STEP_ONE = 16'h0001;
   localparam logic [RBA_PTR_W-1:0] RBA_STEP_TWO = 16'h0002;
   localparam logic [2:0] RBA_SHORT_MIN = 3'h1;
   localparam logic [RBA_PTR_W-1:0] RBA_PTR_RESET = 16'h0000;

   typedef enum logic [2:0] {
      RBA_AUX_LONG = 3'b000,
      RBA_AUX_PRE_LONG = 3'b001,
      RBA_AUX_SHORT = 3'b010,
      RBA_COEFF_PLAIN = 3'b011,
      RBA_COEFF_POST_INC = 3'b100,
      RBA_COEFF_POST_DEC = 3'b101
   } rba_mode_e;

   typedef enum logic [1:0] {
      RBA_OP_CLEAR = 2'b00,
      RBA_OP_SET = 2'b01,
      RBA_OP_PAIR_TEST = 2'b10
   } rba_op_e;
endpackage

// ==== common/rba_addr_if.sv ====
// rba_addr_if: carries a request from the top into the address generator and back.
// assumes both ends on the cpu clock; purely combinational between them.
`timescale 1ns/1ns
`default_nettype none
interface rba_addr_if;
   import rba_pkg::*;
   rba_mode_e mode;
   logic two_bit;
   logic [rba_pkg::RBA_PTR_W-1:0] aux_pointer;
   logic [rba_pkg::RBA_PTR_W-1:0] coeff_pointer;
   logic [rba_pkg::RBA_PTR_W-1:0] long_offset_const;
   logic [2:0] short_offset_const;
   logic circ_en;
   logic [rba_pkg::RBA_PTR_W-1:0] buffer_start;
   logic [rba_pkg::RBA_PTR_W-1:0] bit_addr;
   logic [rba_pkg::RBA_PTR_W-1:0] ptr_new;
   logic ptr_write;
   logic is_coeff;
   logic uses_long;
   modport gen (input mode, two_bit, aux_pointer, coeff_pointer, long_offset_const,
      short_offset_const, circ_en, buffer_start,
      output bit_addr, ptr_new, ptr_write, is_coeff, uses_long);
   modport user (output mode, two_bit, aux_pointer, coeff_pointer, long_offset_const,
      short_offset_const, circ_en, buffer_start,
      input bit_addr, ptr_new, ptr_write, is_coeff, uses_long);
endinterface
`default_nettype wire

// ==== logic/rba_addr_gen.sv ====
// rba_addr_gen: combinational bit address and pointer update for every mode.
// assumes the caller picks the buffer start that matches the pointer in use.
`timescale 1ns/1ns
`default_nettype none
module rba_addr_gen
   import rba_pkg::*;
(
   // request and answer
   rba_addr_if.gen a
);
   logic [RBA_PTR_W-1:0] base;
   logic [RBA_PTR_W-1:0] step;

   always_comb begin
      step = a.two_bit ? RBA_STEP_TWO : RBA_STEP_ONE;
      a.is_coeff = 1'b0;
      a.uses_long = 1'b0;
      a.ptr_write = 1'b0;
      a.ptr_new = a.aux_pointer;
      base = a.aux_pointer;
      unique case (a.mode)
         RBA_AUX_LONG: begin
            base = a.aux_pointer + a.long_offset_const;
            a.uses_long = 1'b1;
         end
         RBA_AUX_PRE_LONG: begin
            a.ptr_new = a.aux_pointer + a.long_offset_const;
            a.ptr_write = 1'b1;
            base = a.ptr_new;
            a.uses_long = 1'b1;
         end
         RBA_AUX_SHORT: begin
            base = a.aux_pointer + {13'h0000, a.short_offset_const};
         end
         RBA_COEFF_PLAIN: begin
            a.is_coeff = 1'b1;
            base = a.coeff_pointer;
            a.ptr_new = a.coeff_pointer;
         end
         RBA_COEFF_POST_INC: begin
            a.is_coeff = 1'b1;
            base = a.coeff_pointer;
            a.ptr_new = a.coeff_pointer + step;
            a.ptr_write = 1'b1;
         end
         RBA_COEFF_POST_DEC: begin
            a.is_coeff = 1'b1;
            base = a.coeff_pointer;
            a.ptr_new = a.coeff_pointer - step;
            a.ptr_write = 1'b1;
         end
         default: begin
            base = a.aux_pointer;
         end
      endcase
      a.bit_addr = a.circ_en ? base + a.buffer_start : base;
   end
endmodule // rba_addr_gen
`default_nettype wire

// ==== logic/rba_unit.sv ====
// rba_unit: register bit address unit; generates bit addresses and does
// set, clear and pair test on a source register, then writes back pointers.
// assumes the decoder pulses req_valid with a stable request for that cycle.
//
// Notes on behaviour
// - aux long offset: pointer plus signed constant
// - long offset instruction never paired parallel
// - pre-modify: update pointer, then use it
// - short offset 1..7 added, pointer kept
// - plain coefficient pointer used, not updated
// - post-increment coefficient by one or two
// - post-decrement coefficient by one or two
// - pair test: low bit, next bit to flags
// - clear selects one bit, others kept
// - set selects one bit, others kept
`timescale 1ns/1ns
`default_nettype none
module rba_unit
   import rba_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // request from decoder
   input wire logic req_valid,
   input wire rba_op_e op,
   input wire rba_mode_e mode,
   input wire logic want_parallel,
   input wire logic [RBA_PTR_W-1:0] long_offset_const,
   input wire logic [2:0] short_offset_const,
   // register file values
   input wire logic [RBA_PTR_W-1:0] aux_pointer,
   input wire logic [RBA_PTR_W-1:0] coeff_pointer,
   input wire logic [RBA_PTR_W-1:0] aux_buffer_start,
   input wire logic [RBA_PTR_W-1:0] coeff_buffer_start,
   input wire logic aux_circ,
   input wire logic coeff_circ,
   input wire logic [RBA_DATA_W-1:0] src_data,
   // results
   output logic done,
   output logic [RBA_PTR_W-1:0] bit_addr,
   output logic [RBA_DATA_W-1:0] result_data,
   output logic result_we,
   output logic test_flag_low,
   output logic test_flag_high,
   output logic flags_we,
   output logic aux_we,
   output logic coeff_we,
   output logic [RBA_PTR_W-1:0] ptr_new,
   output logic parallel_refused
);
   typedef struct packed {
      logic done;
      logic [RBA_PTR_W-1:0] bit_addr;
      logic [RBA_DATA_W-1:0] result_data;
      logic result_we;
      logic test_flag_low;
      logic test_flag_high;
      logic flags_we;
      logic aux_we;
      logic coeff_we;
      logic [RBA_PTR_W-1:0] ptr_new;
      logic parallel_refused;
   } rba_state_s;

   rba_state_s st_r;
   rba_state_s st_nxt;
   rba_addr_if ag ();

   // bit index within the source register; out of range selects nothing
   function automatic logic [RBA_DATA_W-1:0] bit_mask(input logic [RBA_PTR_W-1:0] addr);
      bit_mask = '0;
      if (addr < RBA_PTR_W'(RBA_DATA_W)) begin
         bit_mask[addr[RBA_BIT_W-1:0]] = 1'b1;
      end
   endfunction

   function automatic logic bit_at(input logic [RBA_DATA_W-1:0] d,
      input logic [RBA_PTR_W-1:0] addr);
      bit_at = |(d & bit_mask(addr));
   endfunction

   // decoded from the mode, not from the generator, so no loop through it
   function automatic logic coeff_mode(input rba_mode_e m);
      coeff_mode = (m == RBA_COEFF_PLAIN) || (m == RBA_COEFF_POST_INC) ||
         (m == RBA_COEFF_POST_DEC);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign ag.mode = mode;
   assign ag.two_bit = (op == RBA_OP_PAIR_TEST);
   assign ag.aux_pointer = aux_pointer;
   assign ag.coeff_pointer = coeff_pointer;
   assign ag.long_offset_const = long_offset_const;
   assign ag.short_offset_const = short_offset_const;
   assign ag.circ_en = coeff_mode(mode) ? coeff_circ : aux_circ;
   assign ag.buffer_start = coeff_mode(mode) ? coeff_buffer_start : aux_buffer_start;

   rba_addr_gen u_gen (
      .a(ag.gen)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = '0;
      st_nxt.bit_addr = st_r.bit_addr;
      st_nxt.ptr_new = st_r.ptr_new;
      st_nxt.result_data = st_r.result_data;
      st_nxt.test_flag_low = st_r.test_flag_low;
      st_nxt.test_flag_high = st_r.test_flag_high;
      if (req_valid) begin
         st_nxt.done = 1'b1;
         st_nxt.bit_addr = ag.bit_addr;
         st_nxt.ptr_new = ag.ptr_new;
         // pointer writes happen after the address is used
         st_nxt.aux_we = ag.ptr_write & ~ag.is_coeff;
         st_nxt.coeff_we = ag.ptr_write & ag.is_coeff;
         st_nxt.parallel_refused = ag.uses_long & want_parallel;
         unique case (op)
            RBA_OP_CLEAR: begin
               st_nxt.result_data = src_data & ~bit_mask(ag.bit_addr);
               st_nxt.result_we = 1'b1;
            end
            RBA_OP_SET: begin
               st_nxt.result_data = src_data | bit_mask(ag.bit_addr);
               st_nxt.result_we = 1'b1;
            end
            RBA_OP_PAIR_TEST: begin
               st_nxt.test_flag_low = bit_at(src_data, ag.bit_addr);
               st_nxt.test_flag_high = bit_at(src_data, ag.bit_addr + RBA_STEP_ONE);
               st_nxt.flags_we = 1'b1;
            end
            default: begin
               st_nxt.done = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign done = st_r.done;
   assign bit_addr = st_r.bit_addr;
   assign result_data = st_r.result_data;
   assign result_we = st_r.result_we;
   assign test_flag_low = st_r.test_flag_low;
   assign test_flag_high = st_r.test_flag_high;
   assign flags_we = st_r.flags_we;
   assign aux_we = st_r.aux_we;
   assign coeff_we = st_r.coeff_we;
   assign ptr_new = st_r.ptr_new;
   assign parallel_refused = st_r.parallel_refused;

   ////////////////////////////////////////////////////////////////////////
   property p_long_addr;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_AUX_LONG && !aux_circ) |=>
         bit_addr == $past(aux_pointer) + $past(long_offset_const) && !aux_we;
   endproperty
   a_long_addr: assert property (p_long_addr) else $error("long offset address wrong");

   property p_no_pair;
      @(posedge clk) disable iff (!rstn)
      (req_valid && want_parallel &&
         (mode == RBA_AUX_LONG || mode == RBA_AUX_PRE_LONG)) |=> parallel_refused;
   endproperty
   a_no_pair: assert property (p_no_pair) else $error("long offset paired");

   property p_pre_mod;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_AUX_PRE_LONG && !aux_circ) |=>
         aux_we && ptr_new == bit_addr && !coeff_we;
   endproperty
   a_pre_mod: assert property (p_pre_mod) else $error("pre modify mismatch");

   property p_short;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_AUX_SHORT && !aux_circ) |=>
         bit_addr == $past(aux_pointer) + {13'h0000, $past(short_offset_const)} && !aux_we;
   endproperty
   a_short: assert property (p_short) else $error("short offset address wrong");

   property p_plain;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_COEFF_PLAIN && !coeff_circ) |=>
         bit_addr == $past(coeff_pointer) && !coeff_we;
   endproperty
   a_plain: assert property (p_plain) else $error("plain coefficient wrong");

   property p_inc;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_COEFF_POST_INC) |=> coeff_we &&
         ptr_new == $past(coeff_pointer) +
         ($past(op) == RBA_OP_PAIR_TEST ? RBA_STEP_TWO : RBA_STEP_ONE);
   endproperty
   a_inc: assert property (p_inc) else $error("post increment wrong");

   property p_dec;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_COEFF_POST_DEC) |=> coeff_we &&
         ptr_new == $past(coeff_pointer) -
         ($past(op) == RBA_OP_PAIR_TEST ? RBA_STEP_TWO : RBA_STEP_ONE);
   endproperty
   a_dec: assert property (p_dec) else $error("post decrement wrong");

   property p_pair;
      @(posedge clk) disable iff (!rstn)
      (req_valid && op == RBA_OP_PAIR_TEST && ag.bit_addr == 16'h0015) |=>
         flags_we && test_flag_low == $past(src_data[21]) && test_flag_high == $past(src_data[22]);
   endproperty
   a_pair: assert property (p_pair) else $error("pair test flags wrong");

   property p_clear;
      @(posedge clk) disable iff (!rstn)
      (req_valid && op == RBA_OP_CLEAR && ag.bit_addr == 16'h001f) |=>
         result_we && result_data == ($past(src_data) & ~40'h0080000000);
   endproperty
   a_clear: assert property (p_clear) else $error("bit clear wrong");

   property p_set;
      @(posedge clk) disable iff (!rstn)
      (req_valid && op == RBA_OP_SET && ag.bit_addr == 16'h0000) |=>
         result_we && result_data == ($past(src_data) | 40'h0000000001);
   endproperty
   a_set: assert property (p_set) else $error("bit set wrong");

   property p_circ;
      @(posedge clk) disable iff (!rstn)
      (req_valid && mode == RBA_COEFF_PLAIN && coeff_circ) |=>
         bit_addr == $past(coeff_pointer) + $past(coeff_buffer_start);
   endproperty
   a_circ: assert property (p_circ) else $error("circular base missing");

   c_pair: cover property (@(posedge clk) disable iff (!rstn) flags_we && test_flag_high);
   c_inc: cover property (@(posedge clk) disable iff (!rstn) req_valid && mode == RBA_COEFF_POST_INC);
   c_refuse: cover property (@(posedge clk) disable iff (!rstn) parallel_refused);
endmodule // rba_unit
`default_nettype wire

// ==== test/rba_regfile_model.sv ====
// rba_regfile_model: register file side of the bit address unit.
// assumes the bench loads values between requests; write pulses come from the unit.
`timescale 1ns/1ns
`default_nettype none
module rba_regfile_model
   import rba_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // loads from the bench
   input wire logic load,
   input wire logic [RBA_PTR_W-1:0] load_aux,
   input wire logic [RBA_PTR_W-1:0] load_coeff,
   input wire logic [RBA_DATA_W-1:0] load_src,
   // write back from the unit
   input wire logic aux_we,
   input wire logic coeff_we,
   input wire logic [RBA_PTR_W-1:0] ptr_new,
   input wire logic result_we,
   input wire logic [RBA_DATA_W-1:0] result_data,
   // register values
   output logic [RBA_PTR_W-1:0] aux_pointer,
   output logic [RBA_PTR_W-1:0] coeff_pointer,
   output logic [RBA_DATA_W-1:0] src_data
);
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aux_pointer <= '0;
         coeff_pointer <= '0;
         src_data <= '0;
      end else if (load) begin
         aux_pointer <= load_aux;
         coeff_pointer <= load_coeff;
         src_data <= load_src;
      end else begin
         // write pulses land one edge after the answer, as a real file would
         if (aux_we) aux_pointer <= ptr_new;
         if (coeff_we) coeff_pointer <= ptr_new;
         if (result_we) src_data <= result_data;
      end
   end
endmodule // rba_regfile_model
`default_nettype wire

// ==== test/tb_top.sv ====
// tb_top: random and directed requests against an integer model of the unit.
// assumes one request in flight; write back settles before the next load.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import rba_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, want_parallel = 1'b0, load = 1'b0;
   logic aux_circ = 1'b0, coeff_circ = 1'b0, circ_ok = 1'b0;
   rba_op_e op = RBA_OP_CLEAR;
   rba_mode_e mode = RBA_AUX_LONG;
   logic [15:0] long_offset_const = '0, aux_buffer_start = '0, coeff_buffer_start = '0;
   logic [15:0] load_aux = '0, load_coeff = '0, aux_pointer, coeff_pointer, bit_addr, ptr_new;
   logic [2:0] short_offset_const = 3'h1;
   logic [39:0] load_src = '0, src_data, result_data;
   logic done, result_we, test_flag_low, test_flag_high, flags_we, aux_we, coeff_we;
   logic parallel_refused;
   int err_count = 0, n_compared = 0, seed;
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   rba_unit rba_unit_i (.clk(clk), .rstn(rstn), .req_valid(req_valid), .op(op), .mode(mode),
      .want_parallel(want_parallel), .long_offset_const(long_offset_const),
      .short_offset_const(short_offset_const), .aux_pointer(aux_pointer),
      .coeff_pointer(coeff_pointer), .aux_buffer_start(aux_buffer_start),
      .coeff_buffer_start(coeff_buffer_start), .aux_circ(aux_circ), .coeff_circ(coeff_circ),
      .src_data(src_data), .done(done), .bit_addr(bit_addr), .result_data(result_data),
      .result_we(result_we), .test_flag_low(test_flag_low), .test_flag_high(test_flag_high),
      .flags_we(flags_we), .aux_we(aux_we), .coeff_we(coeff_we), .ptr_new(ptr_new),
      .parallel_refused(parallel_refused));
   rba_regfile_model rba_regfile_model_i (.clk(clk), .rstn(rstn), .load(load),
      .load_aux(load_aux), .load_coeff(load_coeff), .load_src(load_src), .aux_we(aux_we),
      .coeff_we(coeff_we), .ptr_new(ptr_new), .result_we(result_we),
      .result_data(result_data), .aux_pointer(aux_pointer), .coeff_pointer(coeff_pointer),
      .src_data(src_data));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // o: 0 clear, 1 set, 2 pair test; m: mode code; k signed, s short offset
   task automatic run(input int o, input int m, input int a, input int c, input int k,
      input int s);
      int base, addr, step, xa, xc, ba, bc, ah;
      logic ac, cc, wp, fl, fh;
      logic [39:0] d, xr;
      d = 40'({$random(seed), $random(seed)});
      ba = {$random(seed)} % 16;
      bc = {$random(seed)} % 16;
      {ac, cc, wp} = 3'($random(seed));
      // directed cases stay linear so their fixed bit numbers are reached
      if (!circ_ok) {ac, cc} = 2'b00;
      step = (o == 2) ? 2 : 1;
      base = (m < 2) ? a + k : (m == 2) ? a + s : c;
      addr = (base + ((m < 3) ? (ac ? ba : 0) : (cc ? bc : 0))) & 32'hffff;
      xr = d;
      if (o == 0 && addr < 40) xr[addr] = 1'b0;
      if (o == 1 && addr < 40) xr[addr] = 1'b1;
      fl = (addr < 40) ? d[addr] : 1'b0;
      ah = (addr + 1) & 32'hffff;
      fh = (ah < 40) ? d[ah] : 1'b0;
      xa = (m == 1) ? (a + k) & 32'hffff : a;
      xc = (m == 4) ? (c + step) & 32'hffff : (m == 5) ? (c - step) & 32'hffff : c;
      @(posedge clk);
      load <= 1'b1;
      load_aux <= 16'(a);
      load_coeff <= 16'(c);
      load_src <= d;
      aux_buffer_start <= 16'(ba);
      coeff_buffer_start <= 16'(bc);
      aux_circ <= ac;
      coeff_circ <= cc;
      @(posedge clk);
      load <= 1'b0;
      req_valid <= 1'b1;
      op <= rba_op_e'(o);
      mode <= rba_mode_e'(m);
      want_parallel <= wp;
      long_offset_const <= 16'(k);
      short_offset_const <= 3'(s);
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      chk("done", 1, done);
      chk("bit_addr", addr, bit_addr);
      chk("result_we", o < 2, result_we);
      if (o < 2) chk("result_data", xr, result_data);
      chk("flags_we", o == 2, flags_we);
      if (o == 2) chk("test_flag_low", fl, test_flag_low);
      if (o == 2) chk("test_flag_high", fh, test_flag_high);
      chk("aux_we", m == 1, aux_we);
      chk("coeff_we", m > 3, coeff_we);
      if (m == 1 || m > 3) chk("ptr_new", (m == 1) ? xa : xc, ptr_new);
      chk("parallel_refused", wp && m < 2, parallel_refused);
      @(posedge clk);
      #1;
      chk("done", 0, done);
      chk("aux_pointer", xa, aux_pointer);
      chk("coeff_pointer", xc, coeff_pointer);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h440a;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk("done", 0, done);
      run(2, 4, 0, 30, 0, 1);
      run(2, 0, 16, 0, 5, 1);
      run(0, 1, 0, 0, 31, 1);
      run(2, 2, 16, 0, 0, 5);
      run(1, 5, 0, 0, 0, 1);
      run(2, 5, 0, 0, 0, 7);
      run(1, 0, 8, 0, -8, 1);
      run(3, 3, 4, 4, 0, 1);
      circ_ok = 1'b1;
      // every operation against every mode, then random spread
      for (int o = 0; o < 3; o++) begin
         for (int m = 0; m < 6; m++) begin
            run(o, m, {$random(seed)} % 48, {$random(seed)} % 48, $random(seed) % 40,
               1 + {$random(seed)} % 7);
         end
      end
      repeat (200) begin
         run({$random(seed)} % 3, {$random(seed)} % 6, {$random(seed)} % 48,
            {$random(seed)} % 48, $random(seed) % 40, 1 + {$random(seed)} % 7);
      end
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
